/* File: tcpw_timer.sv */
`timescale 1ns/10ps
`include "tcpw_defs.svh"
// Contract
// - force strobe forces match in non-PWM modes
// - forced match sets no flag, no clear
// - force strobe always reads back zero
// - mode is bit3 high, bit6 low
// - top is 0xff, or level in clear mode
// - level buffered at top in PWM; overflow
// - pin overridden when action nonzero, direction
// - non-PWM actions: off, toggle, clear, set
// - fast PWM: clear/set match, opposite at top
// - phase PWM: direction-dependent set or clear
// - PWM level equal top: act at top
// - prescale select stop, 1, 8 to 1024
// - counter write blocks next tick match
// - counter register directly readable and writable
// - level compared continuously with counter
// - compare irq needs mask, global, flag
// - overflow irq needs mask, global, flag
// - compare flag set, cleared by ack/one
// - overflow flag set, cleared by ack/one
// - source clock internal unless async select
module tcpw_timer (
  input wire logic mclk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic ext_clk_tick, // external oscillator edge, sync
  input wire logic port_out, // normal port data for the pin
  input wire logic cmp_vector_ack, // compare vector taken
  input wire logic ovf_vector_ack, // overflow vector taken
  output tcpw_pkg::tcpw_irq_type irq, // interrupt requests
  output logic compare_output_pin, // pin level
  output logic compare_output_oe // pin driver enable
);
  // ==========================================================
  // registers
  tcpw_pkg::tcpw_control_type ctrl;
  logic [7:0] counter_value;
  logic [7:0] compare_level;
  logic [7:0] level_buf;
  logic [1:0] interrupt_mask;
  logic [1:0] interrupt_flags;
  logic [2:0] config_bits;
  logic [`TCPW_PRESCALE_W-1:0] prescale;
  logic wave;
  logic block_match;
  tcpw_pkg::tcpw_dir_type dir;
  logic src_tick;
  logic tick;
  logic [7:0] top;
  logic at_top;
  logic match;
  logic ovf_event;
  logic force_hit;
  logic wr;
  logic rd;
  logic [7:0] next_count;
  tcpw_pkg::tcpw_mode_type mode;
  logic is_pwm;
  logic [1:0] act;
  logic [1:0] force_act;
  logic next_wave;
  // ==========================================================
  // decode
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign mode = tcpw_pkg::tcpw_mode_type'({ctrl.wave_hi, ctrl.wave_lo});
  assign is_pwm = ctrl.wave_lo;
  assign act = ctrl.match_output_action;
  // the action written together with the strobe decides its effect
  assign force_act = pwdata[`TCPW_BIT_ACT_HI:`TCPW_BIT_ACT_LO];
  assign src_tick = config_bits[`TCPW_BIT_ASYNC] ? ext_clk_tick : 1'b1;
  always_comb begin
    unique case (ctrl.clock_prescale_sel)
      3'h0: tick = 1'b0;
      3'h1: tick = src_tick;
      3'h2: tick = src_tick && (prescale[2:0] == 3'h7);
      3'h3: tick = src_tick && (prescale[4:0] == 5'h1f);
      3'h4: tick = src_tick && (prescale[5:0] == 6'h3f);
      3'h5: tick = src_tick && (prescale[6:0] == 7'h7f);
      3'h6: tick = src_tick && (prescale[7:0] == 8'hff);
      3'h7: tick = src_tick && (prescale == 10'h3ff);
    endcase
  end
  assign top = (mode == tcpw_pkg::TCPW_CLEAR) ? compare_level
                                                : `TCPW_MAX;
  assign at_top = counter_value == top;
  assign match = tick && !block_match
                 && counter_value == compare_level;
  assign force_hit = wr && paddr == `TCPW_ADDR_CONTROL && !is_pwm
                     && pwdata[`TCPW_BIT_FORCE];
  always_comb begin
    next_count = counter_value + 8'h01;
    ovf_event = 1'b0;
    unique case (mode)
      tcpw_pkg::TCPW_PHASE: begin
        if (dir == tcpw_pkg::TCPW_DIR_UP) begin
          next_count = at_top ? counter_value - 8'h01 : counter_value + 8'h01;
        end else begin
          next_count = (counter_value == `TCPW_BOTTOM) ? counter_value + 8'h01
                                                       : counter_value - 8'h01;
          ovf_event = counter_value == `TCPW_BOTTOM;
        end
      end
      tcpw_pkg::TCPW_CLEAR: begin
        if (at_top) begin
          next_count = `TCPW_BOTTOM; // forced match never gets here
        end
        ovf_event = counter_value == `TCPW_MAX;
      end
      default: begin
        ovf_event = counter_value == `TCPW_MAX;
      end
    endcase
  end
  // ==========================================================
  // prescaler
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prescale <= '0;
    end else if (src_tick) begin
      prescale <= prescale + 10'h001;
    end
  end
  // ==========================================================
  // counter and direction
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      counter_value <= 8'h00;
      dir <= tcpw_pkg::TCPW_DIR_UP;
      block_match <= 1'b0;
    end else begin
      if (wr && paddr == `TCPW_ADDR_COUNT) begin
        counter_value <= pwdata[7:0];
        block_match <= 1'b1;
      end else if (tick) begin
        counter_value <= next_count;
        block_match <= 1'b0;
      end
      if (tick && mode == tcpw_pkg::TCPW_PHASE) begin
        if (at_top) begin
          dir <= tcpw_pkg::TCPW_DIR_DOWN;
        end else if (counter_value == `TCPW_BOTTOM) begin
          dir <= tcpw_pkg::TCPW_DIR_UP;
        end
      end else if (mode != tcpw_pkg::TCPW_PHASE) begin
        dir <= tcpw_pkg::TCPW_DIR_UP;
      end
    end
  end
  // ==========================================================
  // control, level, mask, config
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl <= `TCPW_CONTROL_RESET;
      level_buf <= 8'h00;
      compare_level <= 8'h00;
      interrupt_mask <= 2'h0;
      config_bits <= 3'h0;
    end else begin
      if (wr && paddr == `TCPW_ADDR_CONTROL) begin
        ctrl <= {1'b0, pwdata[6:0]}; // strobe never stored
      end
      if (wr && paddr == `TCPW_ADDR_LEVEL) begin
        level_buf <= pwdata[7:0];
        if (!is_pwm) begin
          compare_level <= pwdata[7:0];
        end
      end else if (is_pwm && tick && counter_value == `TCPW_MAX) begin
        compare_level <= level_buf;
      end else if (!is_pwm) begin
        compare_level <= level_buf;
      end
      if (wr && paddr == `TCPW_ADDR_MASK) begin
        interrupt_mask <= pwdata[1:0];
      end
      if (wr && paddr == `TCPW_ADDR_CONFIG) begin
        config_bits <= pwdata[2:0];
      end
    end
  end
  // ==========================================================
  // flags: set wins over clear
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      interrupt_flags <= 2'h0;
    end else begin
      if (match) begin
        interrupt_flags[`TCPW_BIT_CMP] <= 1'b1;
      end else if (cmp_vector_ack || (wr && paddr == `TCPW_ADDR_FLAGS
                   && pwdata[`TCPW_BIT_CMP])) begin
        interrupt_flags[`TCPW_BIT_CMP] <= 1'b0;
      end
      if (tick && ovf_event) begin
        interrupt_flags[`TCPW_BIT_OVF] <= 1'b1;
      end else if (ovf_vector_ack || (wr && paddr == `TCPW_ADDR_FLAGS
                   && pwdata[`TCPW_BIT_OVF])) begin
        interrupt_flags[`TCPW_BIT_OVF] <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq <= '0;
    end else begin
      irq.compare_irq <= interrupt_mask[`TCPW_BIT_CMP]
                         && config_bits[`TCPW_BIT_GIE]
                         && interrupt_flags[`TCPW_BIT_CMP];
      irq.overflow_irq <= interrupt_mask[`TCPW_BIT_OVF]
                          && config_bits[`TCPW_BIT_GIE]
                          && interrupt_flags[`TCPW_BIT_OVF];
    end
  end
  // ==========================================================
  // waveform
  always_comb begin
    next_wave = wave;
    if (force_hit) begin
      unique case (force_act)
        2'h0: next_wave = wave;
        2'h1: next_wave = !wave;
        2'h2: next_wave = 1'b0;
        2'h3: next_wave = 1'b1;
      endcase
    end else begin
      unique case (mode)
        tcpw_pkg::TCPW_NORMAL, tcpw_pkg::TCPW_CLEAR: begin
          if (match) begin
            unique case (act)
              2'h0: next_wave = wave;
              2'h1: next_wave = !wave;
              2'h2: next_wave = 1'b0;
              2'h3: next_wave = 1'b1;
            endcase
          end
        end
        tcpw_pkg::TCPW_FAST: begin
          // reserved code 1 leaves the pin level alone
          if (act[1] && tick) begin
            if (compare_level == `TCPW_MAX) begin
              if (counter_value == `TCPW_MAX) begin
                next_wave = act[0];
              end
            end else if (match) begin
              next_wave = act[0];
            end else if (counter_value == `TCPW_MAX) begin
              next_wave = !act[0];
            end
          end
        end
        tcpw_pkg::TCPW_PHASE: begin
          if (act[1] && tick) begin
            if (compare_level == `TCPW_MAX) begin
              if (counter_value == `TCPW_MAX) begin
                next_wave = act[0];
              end
            end else if (match) begin
              if (dir == tcpw_pkg::TCPW_DIR_UP) begin
                next_wave = act[0];
              end else begin
                next_wave = !act[0];
              end
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wave <= 1'b0;
    end else begin
      wave <= next_wave;
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      compare_output_pin <= 1'b0;
      compare_output_oe <= 1'b0;
    end else begin
      compare_output_pin <= (act != 2'h0) ? wave : port_out;
      compare_output_oe <= config_bits[`TCPW_BIT_DIR];
    end
  end
  // ==========================================================
  // apb slave, zero wait states
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          `TCPW_ADDR_CONTROL: prdata <= {24'h0, 1'b0, ctrl[6:0]};
          `TCPW_ADDR_COUNT: prdata <= {24'h0, counter_value};
          `TCPW_ADDR_LEVEL: prdata <= {24'h0, level_buf};
          `TCPW_ADDR_MASK: prdata <= {30'h0, interrupt_mask};
          `TCPW_ADDR_FLAGS: prdata <= {30'h0, interrupt_flags};
          `TCPW_ADDR_CONFIG: prdata <= {29'h0, config_bits};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
  logic unused_rd;
  assign unused_rd = rd;
endmodule // tcpw_timer

/* File: tcpw_defs.svh */
`ifndef TCPW_DEFS_SVH
`define TCPW_DEFS_SVH
// ==========================================================
// register byte addresses
`define TCPW_ADDR_CONTROL 12'h0b0
`define TCPW_ADDR_COUNT 12'h0b4
`define TCPW_ADDR_LEVEL 12'h0b8
`define TCPW_ADDR_MASK 12'h0bc
`define TCPW_ADDR_FLAGS 12'h0c0
`define TCPW_ADDR_CONFIG 12'h0c4
// ==========================================================
// field positions
`define TCPW_BIT_FORCE 7
`define TCPW_BIT_WAVE_LO 6
`define TCPW_BIT_ACT_HI 5
`define TCPW_BIT_ACT_LO 4
`define TCPW_BIT_WAVE_HI 3
`define TCPW_BIT_CMP 1
`define TCPW_BIT_OVF 0
`define TCPW_BIT_GIE 0
`define TCPW_BIT_ASYNC 1
`define TCPW_BIT_DIR 2
// ==========================================================
// reset values and constants
`define TCPW_CONTROL_RESET 8'h00
`define TCPW_MAX 8'hff
`define TCPW_BOTTOM 8'h00
`define TCPW_PRESCALE_W 10
`endif

/* File: tcpw_pkg.sv */
package tcpw_pkg;
  typedef enum logic [1:0] {
    TCPW_NORMAL = 2'h0,
    TCPW_PHASE = 2'h1,
    TCPW_CLEAR = 2'h2,
    TCPW_FAST = 2'h3
  } tcpw_mode_type;

  typedef struct packed {
    logic force_compare_strobe;
    logic wave_lo;
    logic [1:0] match_output_action;
    logic wave_hi;
    logic [2:0] clock_prescale_sel;
  } tcpw_control_type;

  typedef struct packed {
    logic compare_irq;
    logic overflow_irq;
  } tcpw_irq_type;

  typedef enum logic [1:0] {
    TCPW_DIR_UP = 2'b01,
    TCPW_DIR_DOWN = 2'b10
  } tcpw_dir_type;
endpackage

/* File: tcpw_chk_properties.sv */
`timescale 1ns/10ps
// ==========================================
// apb and interrupt request checks
module tcpw_chk (
  input wire logic mclk, // clock
  input wire logic nrst, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic cmp_vector_ack, // compare ack
  input wire logic ovf_vector_ack, // overflow ack
  input wire tcpw_pkg::tcpw_irq_type irq, // requests
  input wire logic compare_output_oe // driver enable
);
  logic [1:0] quiet;
  wire wr = pready && pwrite;
  wire cfg = wr && paddr == 12'h0c4;
  wire map = paddr >= 12'h0b0 && paddr <= 12'h0c4 && paddr[1:0] == 2'h0;
  // cycles since anything that may lower a request
  always_ff @(posedge mclk) begin
    if (!nrst || wr || cmp_vector_ack || ovf_vector_ack) begin
      quiet <= 2'h0;
    end else if (quiet != 2'h3) begin
      quiet <= quiet + 2'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_rdy; pready |-> psel && penable && $past(psel && !penable);
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready w/o setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_err; pready |-> pslverr == !map; endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  property p_up; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_up: assert property (p_up) else $error("upper bits set");
  property p_frc; pready && !pwrite && paddr == 12'h0b0 |-> !prdata[7];
  endproperty
  a_frc: assert property (p_frc) else $error("strobe reads one");
  property p_oe;
    $changed(compare_output_oe) |-> $past(cfg, 1) || $past(cfg, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("oe w/o write");
  property p_cf; $fell(irq.compare_irq) |-> quiet < 2'h3; endproperty
  a_cf: assert property (p_cf) else $error("cmp irq fell");
  property p_of; $fell(irq.overflow_irq) |-> quiet < 2'h3; endproperty
  a_of: assert property (p_of) else $error("ovf irq fell");
  cover property (pready && pslverr);
  cover property ($rose(irq.compare_irq));
  cover property ($rose(irq.overflow_irq));
endmodule // tcpw_chk
bind tcpw_timer tcpw_chk u_chk (.mclk, .nrst, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .cmp_vector_ack, .ovf_vector_ack,
  .irq, .compare_output_oe);

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, er, p;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, lf = 32'h67bf;
  logic pready, pslverr, port_out = 0, cack = 0, oack = 0, pin, oe;
  logic [1:0] c;
  tcpw_pkg::tcpw_irq_type irq;
  int failures = 0, compares = 0, i, r, n;
  always #20 mclk = ~mclk;
  tcpw_timer DUT (.mclk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_clk_tick(1'b0), .port_out,
    .cmp_vector_ack(cack), .ovf_vector_ack(oack), .irq,
    .compare_output_pin(pin), .compare_output_oe(oe));
  // ==========================================
  // helpers
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int dv(input int s);
    int t[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    return t[s];
  endfunction
  function automatic logic pexp(input logic [1:0] a, input logic q);
    return a == 2'h1 ? !q : a[0];
  endfunction
  task automatic chk(input string s, input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic xf(input logic [11:0] a, input logic w, input int d);
    int k;
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    if (k == 20) failures++;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wirq(input int s);
    int k;
    for (k = 0; k < 40 && irq[s] !== 1'b1; k++) @(posedge mclk);
  endtask
  task automatic end_sim;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #(40 * 40000);
    failures++;
    end_sim;
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1;
    xf(12'h0b0, 0, 0);
    chk("ctrl rst", rd, 0);
    for (i = 0; i < 4; i++) begin
      lf = nx(lf);
      xf(12'h0b0, 1, {lf[7] & ~lf[6], lf[6:3], 3'h0});
      xf(12'h0b0, 0, 0);
      chk("ctrl", rd, {lf[6:3], 3'h0});
      xf(12'h0b4, 1, lf[15:8]);
      xf(12'h0b4, 0, 0);
      chk("count", rd, lf[15:8]);
      xf(12'h0b8, 1, lf[23:16]);
      xf(12'h0b8, 0, 0);
      chk("level", rd, lf[23:16]);
    end
    xf(12'h0fc, 0, 0);
    chk("slverr", er, 1);
    xf(12'h0c4, 1, 4);
    port_out <= 1;
    xf(12'h0b0, 1, 8'h80);
    repeat (3) @(posedge mclk);
    chk("oe", oe, 1);
    chk("port pin", pin, 1);
    for (i = 0; i < 6; i++) begin
      c = 2'(3 - i % 3);
      xf(12'h0b0, 1, {2'b10, c, 4'h0});
      repeat (3) @(posedge mclk);
      p = pexp(c, p);
      chk("force pin", pin, p);
    end
    xf(12'h0b4, 1, 5);
    xf(12'h0b0, 1, 8'hb8);
    xf(12'h0b4, 0, 0);
    chk("ctc force", rd, 5);
    xf(12'h0c0, 0, 0);
    chk("force flags", rd[1:0], 0);
    for (i = 0; i < 8; i++) begin
      xf(12'h0b4, 1, 0);
      xf(12'h0b0, 1, i);
      repeat (4 * dv(i)) @(posedge mclk);
      xf(12'h0b0, 1, 0);
      xf(12'h0b4, 0, 0);
      r = rd;
      n = i == 0 ? 0 : (4 * dv(i) + 3) / dv(i);
      chk("prescale", r >= n - 1 && r <= n + 1, 1);
    end
    xf(12'h0c0, 1, 3);
    xf(12'h0bc, 1, 1);
    xf(12'h0c4, 1, 5);
    xf(12'h0b4, 1, 8'hf8);
    xf(12'h0b0, 1, 1);
    wirq(0);
    chk("ovf irq", irq[0], 1);
    xf(12'h0c0, 1, 1);
    repeat (3) @(posedge mclk);
    chk("ovf w1c", irq[0], 0);
    xf(12'h0bc, 1, 0);
    repeat (300) @(posedge mclk);
    xf(12'h0c0, 0, 0);
    chk("ovf flag", rd[0], 1);
    chk("ovf masked", irq[0], 0);
    xf(12'h0bc, 1, 1);
    wirq(0);
    oack <= 1;
    @(posedge mclk);
    oack <= 0;
    repeat (3) @(posedge mclk);
    chk("ovf ack", irq[0], 0);
    xf(12'h0b0, 1, 0);
    xf(12'h0b8, 1, 8'h10);
    xf(12'h0b4, 1, 0);
    xf(12'h0c0, 1, 3);
    xf(12'h0bc, 1, 2);
    xf(12'h0b0, 1, 8'h19);
    wirq(1);
    chk("cmp irq", irq[1], 1);
    for (i = 0; i < 4; i++) begin
      xf(12'h0b4, 0, 0);
      chk("ctc top", rd <= 8'h10, 1);
    end
    xf(12'h0b0, 1, 8'h18);
    cack <= 1;
    @(posedge mclk);
    cack <= 0;
    repeat (3) @(posedge mclk);
    chk("cmp ack", irq[1], 0);
    xf(12'h0b0, 1, 0);
    xf(12'h0b8, 1, 8'h20);
    xf(12'h0b4, 1, 8'h80);
    xf(12'h0c0, 1, 3);
    xf(12'h0b0, 1, 1);
    xf(12'h0b4, 1, 8'h20);
    xf(12'h0c0, 0, 0);
    chk("write blocks", rd[1], 0);
    xf(12'h0b0, 1, 0);
    xf(12'h0b8, 1, 8'h40);
    for (i = 0; i < 2; i++) begin
      xf(12'h0b0, 1, i == 0 ? 8'h69 : 8'h61);
      repeat (520) @(posedge mclk);
      n = 0;
      for (r = 0; r < 510; r++) begin
        @(posedge mclk);
        n += pin;
      end
      chk("pwm duty", n >= 120 && n <= 138, 1);
    end
    end_sim;
  end
endmodule // tb_top
